/* File: inc/pch_regs.svh */
`ifndef PCH_REGS_SVH
`define PCH_REGS_SVH

// Register byte offsets
`define PCH_OFS_ID       8'h00
`define PCH_OFS_CSR      8'h04
`define PCH_OFS_CLASS    8'h08

// Command word bit positions
`define PCH_BIT_IO_EN    0
`define PCH_BIT_MEM_EN   1
`define PCH_BIT_BM_EN    2
`define PCH_BIT_PARITY_RESPONSE_ENABLE   6
`define PCH_BIT_SYSTEM_ERROR_DRIVE_ENABLE  8

// Status byte field positions
`define PCH_SEL_LSB      25
`define PCH_SEL_MSB      26

// Constant field values
`define PCH_SEL_TIMING   2'h1
`define PCH_CLASS_BASE   8'h06
`define PCH_CLASS_SUB    8'h80
`define PCH_CLASS_PROG   8'h00
`define PCH_CLASS_REV    8'h01

// Reset values
`define PCH_FLAG_RST     1'b0
`define PCH_CTL_RST      2'h0
`define PCH_RDATA_RST    32'h0000_0000

`endif

/* File: inc/pch_pkg.sv */
package pch_pkg;

  typedef struct packed {
    logic       req;
    logic       we;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } pch_cfg_req_s;

  typedef struct packed {
    logic mst_active;
    logic mst_data_perr;
    logic tgt_perr_seen;
    logic tgt_addr_perr;
    logic tgt_data_perr;
    logic mst_abort_rcvd;
    logic tgt_abort_rcvd;
    logic tgt_abort_sent;
  } pch_evt_s;

  typedef struct packed {
    logic perresp;
    logic system_error_drive_enable;
  } pch_ctl_s;

  typedef struct packed {
    logic bm;
    logic ms;
    logic io_space_enable;
  } pch_en_s;

endpackage

/* File: rtl/pch_flag_cell.sv */
`timescale 1ns/1ps
module pch_flag_cell (
  input  wire logic ref_clk_i,
  input  wire logic rst_b_i,
  input  wire logic set_i,
  input  wire logic clr_i,
  output logic      flag_o
);
  import pch_pkg::*;
  `include "pch_regs.svh"

  logic flag_q;
  logic flag_d;

  always_comb begin
    flag_d = set_i | (flag_q & ~clr_i);
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      flag_q <= `PCH_FLAG_RST;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign flag_o = flag_q;

  set_wins_a : assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    set_i |=> flag_o)
    else $error("flag lost a set event");

  zero_keeps_a : assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    flag_o && !clr_i |=> flag_o)
    else $error("flag dropped without a clear");
endmodule // pch_flag_cell

/* File: rtl/pch_config_regs.sv */
// How it works
// - Detected-parity flag sets on master data or target address/data errors.
// - System-error-signalled flag sets when SERR# is driven; write one clears.
// - SERR# is never driven unless the system-error drive enable is set.
// - Master-abort-received flag sets on own transaction master-abort; W1C.
// - Target-abort-received flag sets when target aborts own transaction; W1C.
// - Target-abort-signalled flag sets when our target signals abort; W1C.
// - Select timing field always reads 01; writes ignored.
// - Data-parity-reported flag sets only with parity response, as bus master.
// - Both fast back-to-back bits read as zero.
// - PERR# reports data parity errors only when parity response enabled.
// - Address parity errors rejected only with parity response and SERR# on.
// - Wait, palette, write-invalidate and special-cycle bits read zero.
// - VMEbus slave images respond only while bus master enable set.
// - Posted writes drain regardless; new entries wait for bus master enable.
// - Memory and I/O target decode enables are read/write, one enables.
// - Master, memory, I/O enables reset by power-up and VMEbus reset only, to one if either option pin is set.
// - Identification word holds device id high, vendor id low, read-only.
`timescale 1ns/1ps
module pch_config_regs #(
  parameter logic [15:0] DEVICE_ID = 16'h5a01, // Arbitrary value
  parameter logic [15:0] VENDOR_ID = 16'h7c3d  // Arbitrary value
) (
  input  wire logic                  ref_clk_i,
  input  wire logic                  rst_b_i,
  input  wire logic                  pci_rst_b_i,
  input  wire logic                  vme_rst_b_i,
  input  wire logic                  reg_access_opt_i,
  input  wire logic                  first_image_opt_i,
  input  wire pch_pkg::pch_cfg_req_s cfg_i,
  output logic                       cfg_ack_o,
  output logic [31:0]                cfg_rdata_o,
  input  wire pch_pkg::pch_evt_s     evt_i,
  output logic                       perr_b_o,
  output logic                       perr_oe_o,
  output logic                       serr_b_o,
  output logic                       serr_oe_o,
  output logic                       addr_reject_o,
  output logic                       slave_image_en_o,
  output logic                       posted_fifo_accept_o,
  output logic                       mem_decode_en_o,
  output logic                       io_decode_en_o
);
  import pch_pkg::*;
  `include "pch_regs.svh"

  // Pin synchronisers
  logic [3:0] pin_raw;
  logic [3:0] pin_meta_q;
  logic [3:0] pin_sync_q;
  logic       all_rst_b;
  logic       pv_rst_b;
  logic       keep_en;

  assign pin_raw = {first_image_opt_i, reg_access_opt_i,
                    vme_rst_b_i, pci_rst_b_i};

  always_ff @(posedge ref_clk_i) begin
    pin_meta_q <= pin_raw;
    pin_sync_q <= pin_meta_q;
  end

  assign all_rst_b = rst_b_i & pin_sync_q[0] & pin_sync_q[1];
  assign pv_rst_b  = rst_b_i & pin_sync_q[1];
  assign keep_en   = pin_sync_q[2] | pin_sync_q[3];

  // Access decode
  logic wr_csr;
  logic rd_req;

  assign wr_csr = cfg_i.req & cfg_i.we & (cfg_i.addr == `PCH_OFS_CSR);
  assign rd_req = cfg_i.req & ~cfg_i.we;

  // Parity and system-error controls
  pch_ctl_s ctl_q;
  pch_ctl_s ctl_d;

  always_comb begin
    ctl_d = ctl_q;
    if (wr_csr && cfg_i.be[0]) begin
      ctl_d.perresp = cfg_i.wdata[`PCH_BIT_PARITY_RESPONSE_ENABLE];
    end
    if (wr_csr && cfg_i.be[1]) begin
      ctl_d.system_error_drive_enable = cfg_i.wdata[`PCH_BIT_SYSTEM_ERROR_DRIVE_ENABLE];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!all_rst_b) begin
      ctl_q <= `PCH_CTL_RST;
    end else begin
      ctl_q <= ctl_d;
    end
  end

  // Master and target enables
  pch_en_s en_q;
  pch_en_s en_d;

  always_comb begin
    en_d = en_q;
    if (wr_csr && cfg_i.be[0]) begin
      en_d.bm  = cfg_i.wdata[`PCH_BIT_BM_EN];
      en_d.ms  = cfg_i.wdata[`PCH_BIT_MEM_EN];
      en_d.io_space_enable = cfg_i.wdata[`PCH_BIT_IO_EN];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!pv_rst_b) begin
      en_q <= {3{keep_en}};
    end else begin
      en_q <= en_d;
    end
  end

  assign slave_image_en_o     = en_q.bm;
  assign posted_fifo_accept_o = en_q.bm;
  assign mem_decode_en_o      = en_q.ms;
  assign io_decode_en_o       = en_q.io_space_enable;

  // Error signalling drivers
  logic perr_q;
  logic perr_d;
  logic serr_q;
  logic serr_d;

  always_comb begin
    perr_d = ctl_q.perresp
             & (evt_i.mst_data_perr | evt_i.tgt_data_perr);
    serr_d = ctl_q.perresp & ctl_q.system_error_drive_enable & evt_i.tgt_addr_perr;
  end

  always_ff @(posedge ref_clk_i) begin
    if (!all_rst_b) begin
      perr_q <= 1'b0;
      serr_q <= 1'b0;
    end else begin
      perr_q <= perr_d;
      serr_q <= serr_d;
    end
  end

  assign perr_b_o      = 1'b0;
  assign perr_oe_o     = perr_q;
  assign serr_b_o      = 1'b0;
  assign serr_oe_o     = serr_q & ctl_q.system_error_drive_enable;
  assign addr_reject_o = evt_i.tgt_addr_perr & ctl_q.perresp
                         & ctl_q.system_error_drive_enable;

  // Sticky status flags, order DPE SSERR RMA RTA STA DPD
  logic [5:0] set_v;
  logic [5:0] clr_v;
  logic [5:0] flag_v;

  assign set_v[5] = evt_i.mst_data_perr | evt_i.tgt_addr_perr
                    | evt_i.tgt_data_perr;
  assign set_v[4] = serr_oe_o;
  assign set_v[3] = evt_i.mst_abort_rcvd;
  assign set_v[2] = evt_i.tgt_abort_rcvd;
  assign set_v[1] = evt_i.tgt_abort_sent;
  assign set_v[0] = ctl_q.perresp & evt_i.mst_active
                    & (evt_i.mst_data_perr | evt_i.tgt_perr_seen);

  assign clr_v = {cfg_i.wdata[31:27], cfg_i.wdata[24]}
                 & {6{wr_csr & cfg_i.be[3]}};

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_flag
      pch_flag_cell u_flag (
        .ref_clk_i (ref_clk_i),
        .rst_b_i   (all_rst_b),
        .set_i     (set_v[gi]),
        .clr_i     (clr_v[gi]),
        .flag_o    (flag_v[gi])
      );
    end
  endgenerate

  // Read path
  logic [31:0] csr_word;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;
  logic        ack_q;

  always_comb begin
    csr_word = 32'h0000_0000;
    csr_word[31:27] = flag_v[5:1];
    csr_word[`PCH_SEL_MSB:`PCH_SEL_LSB] = `PCH_SEL_TIMING;
    csr_word[24] = flag_v[0];
    csr_word[`PCH_BIT_SYSTEM_ERROR_DRIVE_ENABLE] = ctl_q.system_error_drive_enable;
    csr_word[`PCH_BIT_PARITY_RESPONSE_ENABLE]  = ctl_q.perresp;
    csr_word[`PCH_BIT_BM_EN]   = en_q.bm;
    csr_word[`PCH_BIT_MEM_EN]  = en_q.ms;
    csr_word[`PCH_BIT_IO_EN]   = en_q.io_space_enable;
  end

  always_comb begin
    rdata_d = rdata_q;
    if (rd_req) begin
      case (cfg_i.addr)
        `PCH_OFS_ID: begin
          rdata_d = {DEVICE_ID, VENDOR_ID};
        end
        `PCH_OFS_CSR: begin
          rdata_d = csr_word;
        end
        `PCH_OFS_CLASS: begin
          rdata_d = {`PCH_CLASS_BASE, `PCH_CLASS_SUB,
                     `PCH_CLASS_PROG, `PCH_CLASS_REV};
        end
        default: begin
          rdata_d = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!all_rst_b) begin
      rdata_q <= `PCH_RDATA_RST;
      ack_q   <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      ack_q   <= cfg_i.req;
    end
  end

  assign cfg_rdata_o = rdata_q;
  assign cfg_ack_o   = ack_q;

  // Checking helpers
  logic rd_csr_h;
  logic rd_id_h;

  always_ff @(posedge ref_clk_i) begin
    if (!all_rst_b) begin
      rd_csr_h <= 1'b0;
      rd_id_h  <= 1'b0;
    end else begin
      rd_csr_h <= rd_req & (cfg_i.addr == `PCH_OFS_CSR);
      rd_id_h  <= rd_req & (cfg_i.addr == `PCH_OFS_ID);
    end
  end

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!all_rst_b);

  dpe_set_a : assert property (
    (evt_i.mst_data_perr || evt_i.tgt_addr_perr || evt_i.tgt_data_perr)
    |=> flag_v[5])
    else $error("detected parity flag not set");

  sserr_set_a : assert property (serr_oe_o |=> flag_v[4])
    else $error("system error flag not set after SERR drive");

  serr_gate_a : assert property (serr_oe_o |-> ctl_q.system_error_drive_enable)
    else $error("SERR driven while disabled");

  serr_cause_a : assert property (serr_oe_o |->
    $past(evt_i.tgt_addr_perr) && $past(ctl_q.perresp))
    else $error("SERR driven without address parity error");

  rma_set_a : assert property (evt_i.mst_abort_rcvd |=> flag_v[3])
    else $error("master abort flag not set");

  rta_set_a : assert property (evt_i.tgt_abort_rcvd |=> flag_v[2])
    else $error("received target abort flag not set");

  sta_set_a : assert property (evt_i.tgt_abort_sent |=> flag_v[1])
    else $error("signalled target abort flag not set");

  sel_timing_a : assert property (cfg_ack_o && rd_csr_h |->
    cfg_rdata_o[26:25] == 2'h1)
    else $error("select timing field not medium");

  dpd_gate_a : assert property ($rose(flag_v[0]) |->
    $past(ctl_q.perresp) && $past(evt_i.mst_active))
    else $error("data parity reported flag set without cause");

  fbb_zero_a : assert property (cfg_ack_o && rd_csr_h |->
    !cfg_rdata_o[23] && !cfg_rdata_o[9])
    else $error("fast back-to-back bit reads one");

  perr_gate_a : assert property (perr_oe_o |-> $past(ctl_q.perresp)
    && $past(evt_i.mst_data_perr || evt_i.tgt_data_perr))
    else $error("PERR driven without enabled data parity error");

  reject_a : assert property (evt_i.tgt_addr_perr ##0
    ctl_q.perresp ##0 ctl_q.system_error_drive_enable |-> addr_reject_o)
    else $error("address parity error not rejected");

  reject_gate_a : assert property (addr_reject_o |->
    ctl_q.perresp && ctl_q.system_error_drive_enable)
    else $error("address rejected while not enabled");

  ro_zero_a : assert property (cfg_ack_o && rd_csr_h |->
    cfg_rdata_o[7] == 1'b0 && cfg_rdata_o[5:3] == 3'h0)
    else $error("hard-wired zero command bit reads one");

  bm_write_a : assert property (wr_csr && cfg_i.be[0] |=>
    slave_image_en_o == $past(cfg_i.wdata[2])
    && posted_fifo_accept_o == $past(cfg_i.wdata[2]))
    else $error("bus master enable did not follow write");

  dec_write_a : assert property (wr_csr && cfg_i.be[0] |=>
    mem_decode_en_o == $past(cfg_i.wdata[1])
    && io_decode_en_o == $past(cfg_i.wdata[0]))
    else $error("decode enable did not follow write");

  en_hold_a : assert property (@(posedge ref_clk_i) disable iff (!pv_rst_b)
    !wr_csr |=> $stable(en_q))
    else $error("enables changed without write or power-up reset");

  id_read_a : assert property (cfg_ack_o && rd_id_h |->
    cfg_rdata_o == {DEVICE_ID, VENDOR_ID})
    else $error("identification word wrong");

  w1c_clear_a : assert property (wr_csr && cfg_i.be[3]
    && cfg_i.wdata[29] && !evt_i.mst_abort_rcvd |=> !flag_v[3])
    else $error("write one did not clear flag");
endmodule // pch_config_regs

/* File: dv/pch_agent_model.sv */
`timescale 1ns/1ps
module pch_agent_model (
  input  wire logic         ref_clk_i,
  output pch_pkg::pch_evt_s evt_o
);
  import pch_pkg::*;

  initial evt_o = '0;

  // Waits dly+1 falling edges, then one-cycle event pulse
  task automatic pulse(input pch_evt_s e, input int dly);
    repeat (dly + 1) @(negedge ref_clk_i);
    evt_o = e;
    @(negedge ref_clk_i);
    evt_o = '0;
  endtask
endmodule // pch_agent_model

/* File: dv/pci_config_header_regs_tb.sv */
`timescale 1ns/1ps
module pci_config_header_regs_tb;
  import pch_pkg::*;
  localparam logic [15:0] DID = 16'h5a01; // Arbitrary value
  localparam logic [15:0] VENDOR_IDENTIFIER = 16'h7c3d; // Arbitrary value
  localparam logic [7:0]  CSR = 8'h04;
  logic         ref_clk_i = 1'b0;
  logic         rst_b_i   = 1'b0;
  logic         pci_rst_b = 1'b1;
  logic         vme_rst_b = 1'b1;
  logic         opt_reg   = 1'b0;
  logic         opt_img   = 1'b0;
  pch_cfg_req_s cfg       = '0;
  pch_evt_s     evt;
  logic         ack;
  logic [31:0]  rdata;
  logic [31:0]  rd;
  logic         perr_pin;
  logic         serr_pin;
  logic         perr_oe;
  logic         serr_oe;
  logic         rej;
  logic         img_en;
  logic         fifo_en;
  logic         mem_en;
  logic         io_en;
  int           n_fail    = 0;
  int           checked   = 0;
  int           n_serr    = 0;
  int           n_perr    = 0;
  int           n_rej     = 0;

  always #20 ref_clk_i = ~ref_clk_i;

  pch_config_regs #(.DEVICE_ID(DID), .VENDOR_ID(VENDOR_IDENTIFIER)) dut_u (
    .ref_clk_i           (ref_clk_i),
    .rst_b_i             (rst_b_i),
    .pci_rst_b_i         (pci_rst_b),
    .vme_rst_b_i         (vme_rst_b),
    .reg_access_opt_i    (opt_reg),
    .first_image_opt_i   (opt_img),
    .cfg_i               (cfg),
    .cfg_ack_o           (ack),
    .cfg_rdata_o         (rdata),
    .evt_i               (evt),
    .perr_b_o            (perr_pin),
    .perr_oe_o           (perr_oe),
    .serr_b_o            (serr_pin),
    .serr_oe_o           (serr_oe),
    .addr_reject_o       (rej),
    .slave_image_en_o    (img_en),
    .posted_fifo_accept_o(fifo_en),
    .mem_decode_en_o     (mem_en),
    .io_decode_en_o      (io_en)
  );

  pch_agent_model agent_u (
    .ref_clk_i(ref_clk_i),
    .evt_o    (evt)
  );

  always @(posedge ref_clk_i) begin
    if (serr_oe === 1'b1) n_serr++;
    if (perr_oe === 1'b1) n_perr++;
    if (rej === 1'b1) n_rej++;
  end

  task automatic results;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One request, answer exactly one cycle later
  task automatic xfer(input logic we, input logic [7:0] a,
                      input logic [3:0] be, input logic [31:0] wd);
    @(negedge ref_clk_i);
    cfg = '{1'b1, we, a, be, wd};
    @(negedge ref_clk_i);
    cfg.req = 1'b0;
    if (ack !== 1'b1) begin
      n_fail++;
      results();
    end else rd = rdata;
  endtask

  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] e);
    xfer(1'b0, a, 4'h0, 32'h0);
    chk(nm, rd, e);
  endtask

  task automatic pin_rst(input logic vme);
    if (vme) vme_rst_b = 1'b0;
    else pci_rst_b = 1'b0;
    repeat (4) @(negedge ref_clk_i);
    vme_rst_b = 1'b1;
    pci_rst_b = 1'b1;
    repeat (4) @(negedge ref_clk_i);
  endtask

  initial begin
    int k;
    repeat (8) @(negedge ref_clk_i);
    rst_b_i = 1'b1;
    rdc("id", 8'h00, {DID, VENDOR_IDENTIFIER});
    rdc("csr", CSR, 32'h0200_0000);
    rdc("class", 8'h08, 32'h0680_0001);
    rdc("hole", 8'h0c, 32'h0);
    rdc("misalign", 8'h05, 32'h0);
    xfer(1'b1, 8'h00, 4'hf, '1);
    rdc("id ro", 8'h00, {DID, VENDOR_IDENTIFIER});
    xfer(1'b1, CSR, 4'hf, '1);
    rdc("csr ones", CSR, 32'h0200_0147);
    chk("en on", {img_en, fifo_en, mem_en, io_en}, 32'hf);
    xfer(1'b1, CSR, 4'h0, 32'h0);
    rdc("no lanes", CSR, 32'h0200_0147);
    xfer(1'b1, CSR, 4'h1, 32'h0);
    rdc("low byte", CSR, 32'h0200_0100);
    chk("en off", {img_en, fifo_en, mem_en, io_en}, 32'h0);
    agent_u.pulse(8'h10, 0);
    agent_u.pulse(8'hc0, 2);
    rdc("no resp", CSR, 32'h8200_0100);
    chk("no resp pins", n_serr + n_rej + n_perr, 32'h0);
    xfer(1'b1, CSR, 4'h1, 32'h40);
    agent_u.pulse(8'h20, 0);
    rdc("not master", CSR, 32'h8200_0140);
    n_serr = 0;
    n_perr = 0;
    n_rej = 0;
    agent_u.pulse(8'h10, 0);
    agent_u.pulse(8'hc0, 0);
    agent_u.pulse(8'h07, 1);
    rdc("all set", CSR, 32'hfb00_0140);
    chk("pins", n_rej * 100 + n_serr * 10 + n_perr, 32'd111);
    chk("pin levels", {30'h0, perr_pin, serr_pin}, 32'h0);
    xfer(1'b1, CSR, 4'hf, 32'h0000_0140);
    rdc("w0 keeps", CSR, 32'hfb00_0140);
    xfer(1'b1, CSR, 4'h8, 32'h2000_0000);
    rdc("w1c one", CSR, 32'hdb00_0140);
    fork
      agent_u.pulse(8'h01, 0);
      xfer(1'b1, CSR, 4'h8, 32'h0800_0000);
    join
    rdc("set wins", CSR, 32'hdb00_0140);
    xfer(1'b1, CSR, 4'h8, 32'hff00_0000);
    rdc("w1c all", CSR, 32'h0200_0140);
    xfer(1'b1, CSR, 4'h2, 32'h0);
    n_serr = 0;
    n_rej = 0;
    agent_u.pulse(8'h10, 0);
    rdc("serr off", CSR, 32'h8200_0040);
    chk("serr off pins", n_serr + n_rej, 32'h0);
    xfer(1'b1, CSR, 4'h1, 32'h47);
    pin_rst(1'b0);
    rdc("pci rst", CSR, 32'h0200_0007);
    for (k = 0; k < 3; k++) begin
      xfer(1'b1, CSR, 4'h1, (k == 0) ? 32'h7 : 32'h0);
      opt_reg = (k == 1);
      opt_img = (k == 2);
      pin_rst(1'b1);
      rdc("vme rst", CSR, (k == 0) ? 32'h0200_0000 : 32'h0200_0007);
    end
    results();
  end
endmodule // pci_config_header_regs_tb
